// ==== logic/vmt_consts.svh ====
// Register offsets, field positions, reset values and limits of the transition control bank
`ifndef VMT_CONSTS_SVH
`define VMT_CONSTS_SVH

`define VMT_ADDR_W 12
`define VMT_OFF_EXIT_CTL 12'h000
`define VMT_OFF_STORE_CNT 12'h004
`define VMT_OFF_STORE_PTR_LO 12'h008
`define VMT_OFF_STORE_PTR_HI 12'h00c
`define VMT_OFF_LOAD_CNT 12'h010
`define VMT_OFF_LOAD_PTR_LO 12'h014
`define VMT_OFF_LOAD_PTR_HI 12'h018
`define VMT_OFF_ENTRY_CTL 12'h01c
`define VMT_OFF_EXIT_INFO 12'h020
`define VMT_OFF_STATUS 12'h024

`define VMT_BIT_HOST_LONG 9
`define VMT_BIT_ACK_ON_EXIT 15
`define VMT_BIT_GUEST_LONG 9
`define VMT_BIT_ENTRY_SMM 10
`define VMT_BIT_DEFAULT_SMI 11
`define VMT_BIT_INFO_VALID 31
`define VMT_INFO_TYPE_LSB 8
`define VMT_INFO_TYPE_EXT_INT 3'h0

`define VMT_RST_CTL 32'h0000_0000
`define VMT_RST_CNT 32'h0000_0000
`define VMT_RST_PTR 64'h0000_0000_0000_0000

`define VMT_RECORD_BYTES 16
`define VMT_AREA_LIMIT_BYTES 512
`define VMT_REC_INDEX_MSB 31
`define VMT_REC_RSVD_MSB 63
`define VMT_REC_DATA_LSB 64

`endif

// ==== logic/vmt_pkg.sv ====
// Types shared by the transition control bank modules
package vmt_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic [63:0] value;
    logic [31:0] reserved;
    logic [31:0] index;
  } record_type;

  typedef enum logic [1:0] {PH_IDLE, PH_ACK, PH_FINISH} phase_type;
  typedef enum logic {ACK_IDLE, ACK_WAIT} ack_phase_type;

endpackage

// ==== logic/vmt_vector_check.sv ====
// Reserved-bit check of one control vector against its capability masks
`timescale 1ns/1ps
module vmt_vector_check
  import vmt_pkg::*;
#(
  parameter logic [31:0] MUST_ONE = 32'h0000_0000,
  parameter logic [31:0] MAY_ONE = 32'hffff_ffff
) (
  input wire logic [31:0] vector,
  output logic ok
);
  // Bits forced to one must be set, bits not allowed to one must be clear
  assign ok = ((vector & MUST_ONE) == MUST_ONE) && ((vector & ~MAY_ONE) == 32'h0000_0000);
endmodule

// ==== logic/vmt_intr_ack.sv ====
// Acknowledge handshake with the external interrupt controller
`timescale 1ns/1ps
module vmt_intr_ack
  import vmt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic ack_done,
  input wire logic [7:0] ack_vector,
  output logic ack_req,
  output logic done,
  output logic [7:0] vector
);
  typedef struct packed {
    ack_phase_type phase;
    logic done;
    logic [7:0] vector;
  } ack_state_type;

  ack_state_type state;
  ack_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    unique case (state.phase)
      ACK_IDLE: begin
        if (start) begin
          next_state.phase = ACK_WAIT;
        end
      end
      ACK_WAIT: begin
        if (ack_done) begin
          next_state.phase = ACK_IDLE;
          next_state.vector = ack_vector;
          next_state.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '{phase: ACK_IDLE, done: 1'b0, vector: 8'h00};
    end else begin
      state <= next_state;
    end
  end

  assign ack_req = (state.phase == ACK_WAIT);
  assign done = state.done;
  assign vector = state.vector;
endmodule

// ==== logic/vm_transition_controls.sv ====
// Exit and entry control bank with APB access and transition sequencing
// How it works
// - Exit controls are one 32-bit software-written vector.
// - Each exit copies exit bit 9 into code-segment long and both long-mode flags.
// - Interrupt exit with bit 15 set acknowledges, stores vector, marks info valid.
// - Interrupt exit with bit 15 clear skips acknowledge, marks info invalid.
// - Reserved vector bits must match capability masks, else later entries fail.
// - A 32-bit store count gives registers stored per exit.
// - A 64-bit pointer locates the store area of 16-byte records.
// - Records hold index in 31:0, reserved 63:32, value 127:64.
// - A 32-bit load count gives registers loaded per exit.
// - A 64-bit pointer locates the load area of 16-byte records.
// - Entry controls are a separate 32-bit vector.
// - Entry bit 9 loads both long-mode flags during entry.
// - Entry bit 10 selects management mode; must be clear outside it.
// - Entry bit 11 restores default management handling; clear outside that mode.
// - Long-mode active always equals long-mode enable.
// - Interruption info validity is carried in bit 31.
`timescale 1ns/1ps
`include "vmt_consts.svh"
module vm_transition_controls
  import vmt_pkg::*;
#(
  parameter bit LONG_MODE_SUPPORT = 1'b1,
  parameter logic [31:0] EXIT_MUST_ONE = 32'h0000_0000,
  parameter logic [31:0] EXIT_MAY_ONE = 32'h0000_8200,
  parameter logic [31:0] ENTRY_MUST_ONE = 32'h0000_0000,
  parameter logic [31:0] ENTRY_MAY_ONE = 32'h0000_0e00
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire apb_req_type APB_REQ,
  output apb_rsp_type APB_RSP,
  input wire logic EXIT_REQ,
  input wire logic EXIT_EXT_INT,
  input wire logic ENTRY_REQ,
  input wire logic IN_MGMT_MODE,
  output logic INTA_REQ,
  input wire logic INTA_DONE,
  input wire logic [7:0] INTA_VECTOR,
  output logic CS_LONG,
  output logic LONG_MODE_ENABLE_FLAG,
  output logic LONG_MODE_ACTIVE_FLAG,
  output logic SYSTEM_MANAGEMENT_MODE,
  output logic DEFAULT_MGMT_TREATMENT,
  output logic EXIT_DONE,
  output logic ENTRY_DONE,
  output logic ENTRY_FAIL
);
  localparam logic [31:0] LONG_MASK = 32'h1 << `VMT_BIT_HOST_LONG;
  localparam logic [31:0] LONG_KEEP = LONG_MODE_SUPPORT ? 32'hffff_ffff : ~LONG_MASK;
  localparam logic [31:0] AREA_RECORDS = 32'(`VMT_AREA_LIMIT_BYTES / `VMT_RECORD_BYTES);

  typedef struct packed {
    logic [31:0] exit_control_vector;
    logic [31:0] exit_store_count;
    logic [63:0] exit_store_area_pointer;
    logic [31:0] exit_load_count;
    logic [63:0] exit_load_area_pointer;
    logic [31:0] entry_control_vector;
    logic [31:0] exit_info;
    phase_type phase;
    logic cs_long;
    logic long_mode;
    logic mgmt_mode;
    logic default_mgmt;
    logic entry_failed;
    logic [3:0] fail_reason;
    logic exit_done;
    logic entry_done;
    logic entry_fail;
    logic [31:0] prdata;
    logic pslverr;
  } bank_state_type;

  bank_state_type state;
  bank_state_type next_state;

  logic exit_vec_ok;
  logic entry_vec_ok;
  logic ack_start;
  logic ack_done;
  logic [7:0] ack_vector;
  logic [31:0] vectors [2];
  logic [1:0] checks;
  logic store_misaligned;
  logic load_misaligned;
  logic mgmt_misuse;
  logic count_warn;
  logic access;

  // Register index decode, shared by the read and the write paths
  function automatic logic [3:0] reg_index(input logic [11:0] addr);
    unique case (addr)
      `VMT_OFF_EXIT_CTL: reg_index = 4'h0;
      `VMT_OFF_STORE_CNT: reg_index = 4'h1;
      `VMT_OFF_STORE_PTR_LO: reg_index = 4'h2;
      `VMT_OFF_STORE_PTR_HI: reg_index = 4'h3;
      `VMT_OFF_LOAD_CNT: reg_index = 4'h4;
      `VMT_OFF_LOAD_PTR_LO: reg_index = 4'h5;
      `VMT_OFF_LOAD_PTR_HI: reg_index = 4'h6;
      `VMT_OFF_ENTRY_CTL: reg_index = 4'h7;
      `VMT_OFF_EXIT_INFO: reg_index = 4'h8;
      `VMT_OFF_STATUS: reg_index = 4'h9;
      default: reg_index = 4'hf;
    endcase
  endfunction

  assign vectors[0] = state.exit_control_vector;
  assign vectors[1] = state.entry_control_vector;

  // Both vectors face the same reserved-bit test with their own masks
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_check
      vmt_vector_check #(
        .MUST_ONE(g == 0 ? EXIT_MUST_ONE : ENTRY_MUST_ONE),
        .MAY_ONE(g == 0 ? (EXIT_MAY_ONE & LONG_KEEP) : (ENTRY_MAY_ONE & LONG_KEEP))
      ) u_check (
        .vector(vectors[g]),
        .ok(checks[g])
      );
    end
  endgenerate
  assign exit_vec_ok = checks[0];
  assign entry_vec_ok = checks[1];

  assign store_misaligned = (state.exit_store_count != 32'h0) &&
    (state.exit_store_area_pointer[3:0] != 4'h0);
  assign load_misaligned = (state.exit_load_count != 32'h0) &&
    (state.exit_load_area_pointer[3:0] != 4'h0);
  assign mgmt_misuse = !IN_MGMT_MODE &&
    (state.entry_control_vector[`VMT_BIT_ENTRY_SMM] ||
     state.entry_control_vector[`VMT_BIT_DEFAULT_SMI]);
  assign count_warn = (state.exit_store_count > AREA_RECORDS) ||
    (state.exit_load_count > AREA_RECORDS);

  vmt_intr_ack u_ack (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(ack_start),
    .ack_done(INTA_DONE),
    .ack_vector(INTA_VECTOR),
    .ack_req(INTA_REQ),
    .done(ack_done),
    .vector(ack_vector)
  );

  assign access = APB_REQ.psel && APB_REQ.penable;
  assign ack_start = (state.phase == PH_IDLE) && EXIT_REQ && EXIT_EXT_INT &&
    state.exit_control_vector[`VMT_BIT_ACK_ON_EXIT];

  always_comb begin
    next_state = state;
    next_state.exit_done = 1'b0;
    next_state.entry_done = 1'b0;
    next_state.entry_fail = 1'b0;
    next_state.prdata = 32'h0;
    next_state.pslverr = 1'b0;
    // Register bus: zero-wait slave, unmapped addresses answer with an error
    if (APB_REQ.psel && !APB_REQ.penable) begin
      unique case (reg_index(APB_REQ.paddr))
        4'h0: next_state.prdata = state.exit_control_vector;
        4'h1: next_state.prdata = state.exit_store_count;
        4'h2: next_state.prdata = state.exit_store_area_pointer[31:0];
        4'h3: next_state.prdata = state.exit_store_area_pointer[63:32];
        4'h4: next_state.prdata = state.exit_load_count;
        4'h5: next_state.prdata = state.exit_load_area_pointer[31:0];
        4'h6: next_state.prdata = state.exit_load_area_pointer[63:32];
        4'h7: next_state.prdata = state.entry_control_vector;
        4'h8: next_state.prdata = state.exit_info;
        4'h9: next_state.prdata = {16'h0, state.fail_reason, 4'h0, 1'b0,
          state.phase != PH_IDLE, count_warn, state.entry_failed,
          state.default_mgmt, state.mgmt_mode, state.cs_long, state.long_mode};
        default: next_state.pslverr = 1'b1;
      endcase
    end else if (access) begin
      next_state.prdata = state.prdata;
      next_state.pslverr = state.pslverr;
    end
    if (access && APB_REQ.pwrite) begin
      unique case (reg_index(APB_REQ.paddr))
        4'h0: next_state.exit_control_vector = APB_REQ.pwdata;
        4'h1: next_state.exit_store_count = APB_REQ.pwdata;
        4'h2: next_state.exit_store_area_pointer[31:0] = APB_REQ.pwdata;
        4'h3: next_state.exit_store_area_pointer[63:32] = APB_REQ.pwdata;
        4'h4: next_state.exit_load_count = APB_REQ.pwdata;
        4'h5: next_state.exit_load_area_pointer[31:0] = APB_REQ.pwdata;
        4'h6: next_state.exit_load_area_pointer[63:32] = APB_REQ.pwdata;
        4'h7: next_state.entry_control_vector = APB_REQ.pwdata;
        default: next_state.prdata = next_state.prdata;
      endcase
    end
    // Transition sequencing; an exit outranks an entry in the same cycle
    unique case (state.phase)
      PH_IDLE: begin
        if (EXIT_REQ) begin
          next_state.cs_long = state.exit_control_vector[`VMT_BIT_HOST_LONG];
          next_state.long_mode = state.exit_control_vector[`VMT_BIT_HOST_LONG];
          if (EXIT_EXT_INT && state.exit_control_vector[`VMT_BIT_ACK_ON_EXIT]) begin
            next_state.phase = PH_ACK;
          end else begin
            if (EXIT_EXT_INT) begin
              next_state.exit_info[`VMT_BIT_INFO_VALID] = 1'b0;
            end
            next_state.phase = PH_FINISH;
          end
        end else if (ENTRY_REQ) begin
          next_state.fail_reason = {mgmt_misuse, store_misaligned | load_misaligned,
            !entry_vec_ok, !exit_vec_ok};
          if (!exit_vec_ok || !entry_vec_ok || mgmt_misuse || store_misaligned ||
              load_misaligned) begin
            next_state.entry_fail = 1'b1;
            next_state.entry_failed = 1'b1;
          end else begin
            next_state.long_mode = state.entry_control_vector[`VMT_BIT_GUEST_LONG];
            next_state.mgmt_mode = state.entry_control_vector[`VMT_BIT_ENTRY_SMM];
            next_state.default_mgmt =
              state.entry_control_vector[`VMT_BIT_DEFAULT_SMI];
            next_state.entry_failed = 1'b0;
            next_state.entry_done = 1'b1;
          end
        end
      end
      PH_ACK: begin
        if (ack_done) begin
          next_state.exit_info = 32'h0;
          next_state.exit_info[7:0] = ack_vector;
          next_state.exit_info[`VMT_INFO_TYPE_LSB +: 3] = `VMT_INFO_TYPE_EXT_INT;
          next_state.exit_info[`VMT_BIT_INFO_VALID] = 1'b1;
          next_state.phase = PH_FINISH;
        end
      end
      PH_FINISH: begin
        next_state.exit_done = 1'b1;
        next_state.phase = PH_IDLE;
      end
      default: next_state.phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state <= '{
        exit_control_vector: `VMT_RST_CTL,
        exit_store_count: `VMT_RST_CNT,
        exit_store_area_pointer: `VMT_RST_PTR,
        exit_load_count: `VMT_RST_CNT,
        exit_load_area_pointer: `VMT_RST_PTR,
        entry_control_vector: `VMT_RST_CTL,
        exit_info: 32'h0,
        phase: PH_IDLE,
        cs_long: 1'b0,
        long_mode: 1'b0,
        mgmt_mode: 1'b0,
        default_mgmt: 1'b0,
        entry_failed: 1'b0,
        fail_reason: 4'h0,
        exit_done: 1'b0,
        entry_done: 1'b0,
        entry_fail: 1'b0,
        prdata: 32'h0,
        pslverr: 1'b0
      };
    end else begin
      state <= next_state;
    end
  end

  assign APB_RSP.prdata = state.prdata;
  assign APB_RSP.pready = 1'b1;
  assign APB_RSP.pslverr = state.pslverr && access;
  assign CS_LONG = state.cs_long;
  assign LONG_MODE_ENABLE_FLAG = state.long_mode;
  assign LONG_MODE_ACTIVE_FLAG = state.long_mode;
  assign SYSTEM_MANAGEMENT_MODE = state.mgmt_mode;
  assign DEFAULT_MGMT_TREATMENT = state.default_mgmt;
  assign EXIT_DONE = state.exit_done;
  assign ENTRY_DONE = state.entry_done;
  assign ENTRY_FAIL = state.entry_fail;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_host_long_copy: assert property (
    (state.phase == PH_IDLE && EXIT_REQ) |=> (CS_LONG == $past(state.exit_control_vector[9])) &&
      (LONG_MODE_ENABLE_FLAG == $past(state.exit_control_vector[9])))
    else $error("exit did not copy host long-mode control");

  a_ack_on_exit: assert property (
    (state.phase == PH_IDLE && EXIT_REQ && EXIT_EXT_INT && state.exit_control_vector[15])
      |=> INTA_REQ)
    else $error("acknowledge not requested on interrupt exit");

  a_ack_info_valid: assert property (
    (INTA_REQ && INTA_DONE) |=> ##1 (state.exit_info[31] &&
      state.exit_info[7:0] == $past(INTA_VECTOR, 2)) ##1 EXIT_DONE)
    else $error("acknowledged vector not stored as valid");

  a_no_ack_invalid: assert property (
    (state.phase == PH_IDLE && EXIT_REQ && EXIT_EXT_INT && !state.exit_control_vector[15])
      |=> !state.exit_info[31] && !INTA_REQ ##1 EXIT_DONE && !INTA_REQ)
    else $error("interrupt acknowledged or info valid while acknowledge disabled");

  a_entry_reserved: assert property (
    (state.phase == PH_IDLE && !EXIT_REQ && ENTRY_REQ && !(exit_vec_ok && entry_vec_ok))
      |=> ENTRY_FAIL && !ENTRY_DONE)
    else $error("entry with bad reserved bits not failed");

  a_guest_long_load: assert property (
    ENTRY_DONE |-> LONG_MODE_ENABLE_FLAG == $past(state.entry_control_vector[9]))
    else $error("entry did not load guest long mode");

  a_mgmt_outside: assert property (
    (state.phase == PH_IDLE && !EXIT_REQ && ENTRY_REQ && mgmt_misuse) |=> ENTRY_FAIL)
    else $error("management entry from outside mode not failed");

  a_long_flags_equal: assert property (
    LONG_MODE_ACTIVE_FLAG == LONG_MODE_ENABLE_FLAG)
    else $error("long-mode active differs from enable");

  a_exit_finishes: assert property (
    (state.phase == PH_IDLE && EXIT_REQ && !(EXIT_EXT_INT && state.exit_control_vector[15]))
      |=> ##1 EXIT_DONE)
    else $error("exit without acknowledge did not finish in two cycles");

  a_ctl_write: assert property (
    (access && APB_REQ.pwrite && APB_REQ.paddr == `VMT_OFF_EXIT_CTL)
      |=> state.exit_control_vector == $past(APB_REQ.pwdata))
    else $error("exit control vector write lost");

  c_ack_exit: cover property (INTA_REQ ##[1:20] EXIT_DONE);
  c_entry_ok: cover property (ENTRY_DONE && LONG_MODE_ENABLE_FLAG);
  c_entry_fail: cover property (ENTRY_FAIL);
  c_bus_error: cover property (APB_RSP.pslverr);
endmodule

// ==== sim/intr_ctrl_model.sv ====
// Interrupt controller model answering acknowledge requests after a set delay
`timescale 1ns/1ps
module intr_ctrl_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inta_req,
  input wire logic [3:0] delay,
  input wire logic [7:0] vector_in,
  output logic inta_done,
  output logic [7:0] inta_vector
);
  logic [3:0] count;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= 4'h0;
      inta_done <= 1'b0;
      inta_vector <= 8'h5a;
    end else if (inta_req && !inta_done && count == delay) begin
      inta_done <= 1'b1;
      inta_vector <= vector_in;
      count <= 4'h0;
    end else begin
      // Vector is valid only with the answer, so it keeps changing otherwise
      inta_done <= 1'b0;
      inta_vector <= ~inta_vector;
      count <= (inta_req && !inta_done) ? count + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== sim/test_vm_transition_controls.sv ====
// Self-checking testbench of the transition control bank
`timescale 1ns/1ps
`include "vmt_consts.svh"
module test_vm_transition_controls
  import vmt_pkg::*;
;
  logic clk;
  logic reset_n;
  apb_req_type apb_req;
  apb_rsp_type apb_rsp;
  logic exit_req, exit_ext_int, entry_req, in_mgmt;
  logic inta_req, inta_done;
  logic [7:0] inta_vector, vec_in;
  logic [3:0] delay;
  logic cs_long, lme, lma, system_management_mode, dflt, exit_done, entry_done, entry_fail;
  logic [31:0] rd;
  logic err, first_ack, ack_any, f_cs, f_lme, f_lma;
  int n_errors = 0;
  int compares = 0;
  int cyc;

  vm_transition_controls vm_transition_controls_inst (
    .CLK(clk), .RESET_N(reset_n), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
    .EXIT_REQ(exit_req), .EXIT_EXT_INT(exit_ext_int), .ENTRY_REQ(entry_req),
    .IN_MGMT_MODE(in_mgmt), .INTA_REQ(inta_req), .INTA_DONE(inta_done),
    .INTA_VECTOR(inta_vector), .CS_LONG(cs_long), .LONG_MODE_ENABLE_FLAG(lme),
    .LONG_MODE_ACTIVE_FLAG(lma), .SYSTEM_MANAGEMENT_MODE(system_management_mode),
    .DEFAULT_MGMT_TREATMENT(dflt), .EXIT_DONE(exit_done), .ENTRY_DONE(entry_done),
    .ENTRY_FAIL(entry_fail)
  );
  intr_ctrl_model intr_ctrl_model_inst (
    .clk(clk), .reset_n(reset_n), .inta_req(inta_req), .delay(delay),
    .vector_in(vec_in), .inta_done(inta_done), .inta_vector(inta_vector)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    $display("Mismatches %0d in %0d comparisons", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic timed_out();
    n_errors++;
    $display("ERROR at %0t: wait bound used up", $time);
    close_out();
  endtask

  task automatic apb(input logic is_write, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: is_write, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    rdy = 1'b0;
    // Answer is taken at the rising edge, before that edge's updates land
    for (n = 0; n < 20 && rdy !== 1'b1; n++) begin
      @(posedge clk);
      rdy = apb_rsp.pready;
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
    end
    if (rdy !== 1'b1) timed_out();
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask

  task automatic do_exit(input logic ext, input logic [3:0] d, input logic [7:0] v);
    @(posedge clk);
    exit_req <= 1'b1;
    exit_ext_int <= ext;
    delay <= d;
    vec_in <= v;
    @(posedge clk);
    exit_req <= 1'b0;
    exit_ext_int <= 1'b0;
    @(negedge clk);
    first_ack = inta_req;
    ack_any = inta_req;
    f_cs = cs_long;
    f_lme = lme;
    f_lma = lma;
    for (cyc = 1; cyc < 40 && exit_done !== 1'b1; cyc++) begin
      @(negedge clk);
      ack_any = ack_any | inta_req;
    end
    if (cyc >= 40) timed_out();
  endtask

  task automatic t_reset();
    for (int i = 0; i < 10; i++) rchk(12'(i * 4), 32'h0000_0000, "reset");
    chk(err, 1'b0, "mapped error");
    wr(`VMT_OFF_EXIT_INFO, 32'hffff_ffff);
    wr(`VMT_OFF_STATUS, 32'hffff_ffff);
    rchk(`VMT_OFF_EXIT_INFO, 32'h0000_0000, "info write");
    rchk(`VMT_OFF_STATUS, 32'h0000_0000, "status write");
    wr(12'h028, 32'hffff_ffff);
    chk(err, 1'b1, "unmapped write");
    rchk(12'h028, 32'h0000_0000, "unmapped read");
    chk(err, 1'b1, "unmapped read error");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) wr(12'(i * 4), 32'hc3a5_0f00 | 32'(i));
    for (int i = 0; i < 8; i++) rchk(12'(i * 4), 32'hc3a5_0f00 | 32'(i), "rw");
    for (int i = 0; i < 8; i++) wr(12'(i * 4), 32'h0000_0000);
  endtask

  task automatic t_exit_long();
    for (int b = 1; b >= 0; b--) begin
      wr(`VMT_OFF_EXIT_CTL, 32'(b) << `VMT_BIT_HOST_LONG);
      do_exit(1'b0, 4'h0, 8'h00);
      chk(f_cs, 32'(b), "cs long");
      chk(f_lme, 32'(b), "long enable");
      chk(f_lma, 32'(b), "long active");
      chk(cyc, 32'd2, "exit latency");
    end
  endtask

  task automatic t_exit_int();
    for (int d = 0; d < 4; d += 3) begin
      wr(`VMT_OFF_EXIT_CTL, 32'h1 << `VMT_BIT_ACK_ON_EXIT);
      do_exit(1'b1, 4'(d), 8'h40 + 8'(d));
      chk(first_ack, 1'b1, "ack raised");
      rchk(`VMT_OFF_EXIT_INFO, 32'h8000_0040 + 32'(d), "info valid");
    end
    wr(`VMT_OFF_EXIT_CTL, 32'h0000_0000);
    do_exit(1'b1, 4'h0, 8'h77);
    chk(ack_any, 1'b0, "no ack");
    chk(cyc, 32'd2, "no ack latency");
    apb(1'b0, `VMT_OFF_EXIT_INFO, 32'h0000_0000);
    chk(rd[31], 1'b0, "info invalid");
  endtask

  task automatic entry_case(input logic [31:0] ev, input logic [31:0] xv, input logic mgmt,
                            input logic [31:0] sc, input logic [31:0] sp,
                            input logic [31:0] lc, input logic [31:0] lp, input logic ok);
    logic [3:0] prior, exp;
    wr(`VMT_OFF_EXIT_CTL, xv);
    wr(`VMT_OFF_ENTRY_CTL, ev);
    wr(`VMT_OFF_STORE_CNT, sc);
    wr(`VMT_OFF_STORE_PTR_LO, sp);
    wr(`VMT_OFF_LOAD_CNT, lc);
    wr(`VMT_OFF_LOAD_PTR_LO, lp);
    @(negedge clk);
    prior = {lme, lma, system_management_mode, dflt};
    exp = ok ? {ev[9], ev[9], ev[10], ev[11]} : prior;
    @(posedge clk);
    entry_req <= 1'b1;
    in_mgmt <= mgmt;
    @(posedge clk);
    entry_req <= 1'b0;
    @(negedge clk);
    chk(entry_done, ok, "entry done");
    chk(entry_fail, !ok, "entry fail");
    chk({lme, lma, system_management_mode, dflt}, exp, "entry flags");
    apb(1'b0, `VMT_OFF_STATUS, 32'h0000_0000);
    chk(rd[4], !ok, "fail status");
  endtask

  task automatic t_entry();
    entry_case(32'h0e00, 32'h0, 1'b1, 32'h0, 32'h0, 32'h0, 32'h0, 1'b1);
    entry_case(32'h0200, 32'h0, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b1);
    entry_case(32'h0400, 32'h0, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0);
    entry_case(32'h0800, 32'h0, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0);
    entry_case(32'h0001, 32'h0, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0);
    entry_case(32'h0000, 32'h1, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0);
    entry_case(32'h0000, 32'h0, 1'b0, 32'h1, 32'h8, 32'h0, 32'h0, 1'b0);
    entry_case(32'h0000, 32'h0, 1'b0, 32'h0, 32'h8, 32'h0, 32'h0, 1'b1);
    entry_case(32'h0200, 32'h0, 1'b0, 32'h0, 32'h0, 32'h2, 32'h4, 1'b0);
    entry_case(32'h0200, 32'h0, 1'b0, 32'h2, 32'h10, 32'h2, 32'h10, 1'b1);
  endtask

  task automatic t_count();
    logic [31:0] sc [3] = '{32'd32, 32'd33, 32'd0};
    logic [31:0] lc [3] = '{32'd32, 32'd0, 32'd33};
    for (int i = 0; i < 3; i++) begin
      wr(`VMT_OFF_STORE_CNT, sc[i]);
      wr(`VMT_OFF_LOAD_CNT, lc[i]);
      apb(1'b0, `VMT_OFF_STATUS, 32'h0000_0000);
      chk(rd[5], 32'(i != 0), "count warning");
    end
  endtask

  task automatic t_record();
    record_type r;
    r = '{value: 64'h1122_3344_5566_7788, reserved: 32'h0, index: 32'hc000_0080};
    chk(r[31:0], 32'hc000_0080, "record index");
    chk(r[127:96], 32'h1122_3344, "record value");
  endtask

  initial begin
    apb_req = '0;
    reset_n = 1'b0;
    exit_req = 1'b0;
    exit_ext_int = 1'b0;
    entry_req = 1'b0;
    in_mgmt = 1'b0;
    delay = 4'h0;
    vec_in = 8'h00;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_exit_long();
    t_exit_int();
    t_entry();
    t_count();
    t_record();
    close_out();
  end
endmodule
